// [common/nsw_defs.vh]
// constants for the nvm self-write sequencer
`ifndef NSW_DEFS_VH
`define NSW_DEFS_VH

// ----------------------------------------------------------------
// unlock keys
// ----------------------------------------------------------------
`define NSW_KEY_FIRST        8'h55
`define NSW_KEY_SECOND       8'haa

// ----------------------------------------------------------------
// address map, region select clear
// ----------------------------------------------------------------
`define NSW_PFM_LAST         15'h7fff
`define NSW_ROW_LSB          5

// ----------------------------------------------------------------
// address map, region select set
// ----------------------------------------------------------------
`define NSW_UID_LAST         15'h0003
`define NSW_RSVD_ADDR        15'h0004
`define NSW_REV_ADDR         15'h0005
`define NSW_DEV_ADDR         15'h0006
`define NSW_CFG_FIRST        15'h0007
`define NSW_CFG_LAST         15'h000b
`define NSW_DIA_FIRST        15'h0100
`define NSW_DIA_LAST         15'h02ff
`define NSW_EE_FIRST         15'h7000
`define NSW_EE_LAST          15'h70ff

// ----------------------------------------------------------------
// reset values and timing
// ----------------------------------------------------------------
`define NSW_DATA_RESET       14'h0000
`define NSW_LATCH_BLANK      14'h3fff
`define NSW_EE_WRITE_CYCLES  16
`define NSW_ERASE_CYCLES     32
`define NSW_FLASH_CYCLES     32

`endif

// [verilog/nsw_region_decode.v]
// address region decoder for nvm self-write accesses
`timescale 1ns/100ps

module nsw_region_decode (
    input  wire [14:0] i_addr,
    input  wire        i_region_select,
    output reg         o_readable,
    output reg         o_writable,
    output reg         o_is_eeprom,
    output reg         o_is_flash_row
);

`include "nsw_defs.vh"

    always @* begin
        o_readable     = 1'b0;
        o_writable     = 1'b0;
        o_is_eeprom    = 1'b0;
        o_is_flash_row = 1'b0;
        if (!i_region_select) begin
            // whole 15-bit space is program flash
            o_readable     = (i_addr <= `NSW_PFM_LAST);
            o_writable     = (i_addr <= `NSW_PFM_LAST);
            o_is_flash_row = 1'b1;
        end else if (i_addr <= `NSW_UID_LAST) begin
            o_readable     = 1'b1;
            o_writable     = 1'b1;
            o_is_flash_row = 1'b1;
        end else if (i_addr == `NSW_REV_ADDR ||
                     i_addr == `NSW_DEV_ADDR) begin
            o_readable = 1'b1;
        end else if (i_addr >= `NSW_CFG_FIRST &&
                     i_addr <= `NSW_CFG_LAST) begin
            o_readable = 1'b1;
            o_writable = 1'b1;
        end else if (i_addr >= `NSW_DIA_FIRST &&
                     i_addr <= `NSW_DIA_LAST) begin
            o_readable = 1'b1;
        end else if (i_addr >= `NSW_EE_FIRST &&
                     i_addr <= `NSW_EE_LAST) begin
            o_readable  = 1'b1;
            o_writable  = 1'b1;
            o_is_eeprom = 1'b1;
        end
        // 0x0004 and unlisted addresses: no operation
    end

endmodule // nsw_region_decode

// [verilog/nsw_sequencer.v]
// nvm self-write sequencer: unlock, start, stall and completion logic
//
// Operation
// - every write or erase needs the unlock
// - keys 0x55, 0xaa, then set write-start
// - steps on consecutive cycles, else abort
// - core stalled until flash operation finishes
// - eeprom write implicit erase, core runs
// - completion clears start, sets done flag unless latch-only
// - clearing start never aborts eeprom write
// - whole-row erase only, no auto erase
// - protected row clears start, no erase
// - row erase stalls core, flags done
// - erase keeps latches and write permit
// - region clear selects program flash
// - user ids writable, 0x0004 no operation
// - revision and device id read only
// - eeprom bytes read and write
// - read stalls, data next cycle, self-clears
// - protected target blocks writes and erases
`timescale 1ns/100ps

`include "nsw_defs.vh"

module nsw_sequencer #(
    parameter EE_CYCLES    = `NSW_EE_WRITE_CYCLES,
    parameter ERASE_CYCLES = `NSW_ERASE_CYCLES,
    parameter FLASH_CYCLES = `NSW_FLASH_CYCLES
) (
    input  wire        i_ref_clk,
    input  wire        i_reset,
    // core register writes, one per instruction cycle
    input  wire        i_unlock_key_we,
    input  wire [7:0]  i_unlock_key_data,
    input  wire        i_control_we,
    input  wire        i_write_start_wdata,
    input  wire        i_read_start_wdata,
    input  wire        i_region_select,
    input  wire        i_write_permit,
    input  wire        i_erase_select,
    input  wire        i_latch_only_select,
    input  wire [14:0] i_nvm_address_pair,
    input  wire        i_data_we,
    input  wire [13:0] i_data_wdata,
    input  wire        i_write_protect,
    input  wire        i_done_flag_clear,
    input  wire        i_nvm_done_irq_enable,
    // memory array side
    input  wire [13:0] i_mem_rdata,
    output reg         o_mem_read,
    output reg         o_mem_row_erase,
    output reg         o_mem_latch_load,
    output reg         o_mem_row_write,
    output reg         o_mem_ee_write,
    output reg  [14:0] o_mem_addr,
    output reg  [13:0] o_mem_wdata,
    // status towards the core
    output reg         o_cpu_stall,
    output reg         o_write_start,
    output reg         o_read_start,
    output reg  [13:0] o_nvm_data_pair,
    output reg         o_nvm_done_flag,
    output reg         o_nvm_irq
);

    // ----------------------------------------------------------------
    // states
    // ----------------------------------------------------------------
    localparam ST_IDLE  = 5'b00001;
    localparam ST_KEY1  = 5'b00010;
    localparam ST_KEY2  = 5'b00100;
    localparam ST_BUSY  = 5'b01000;
    localparam ST_READ  = 5'b10000;

    localparam [1:0] OP_EE    = 2'd0;
    localparam [1:0] OP_ERASE = 2'd1;
    localparam [1:0] OP_WRITE = 2'd2;
    localparam [1:0] OP_LATCH = 2'd3;

    reg  [4:0]  state;
    reg  [1:0]  op;
    reg  [15:0] busy_count;

    wire        readable;
    wire        writable;
    wire        is_eeprom;
    wire        is_flash_row;

    nsw_region_decode u_decode (
        .i_addr          (i_nvm_address_pair),
        .i_region_select (i_region_select),
        .o_readable      (readable),
        .o_writable      (writable),
        .o_is_eeprom     (is_eeprom),
        .o_is_flash_row  (is_flash_row)
    );

    function [15:0] op_cycles;
        input [1:0] kind;
        begin
            case (kind)
                OP_EE:    op_cycles = EE_CYCLES[15:0];
                OP_ERASE: op_cycles = ERASE_CYCLES[15:0];
                OP_WRITE: op_cycles = FLASH_CYCLES[15:0];
                default:  op_cycles = 16'd1;
            endcase
        end
    endfunction

    wire start_req = i_control_we & i_write_start_wdata;
    // a start is only honoured from the second key, one cycle later
    wire unlocked  = (state == ST_KEY2) & start_req;
    wire allowed   = unlocked & i_write_permit & writable &
                     ~i_write_protect;
    wire [1:0] next_op = is_eeprom ? OP_EE :
                         (i_erase_select & is_flash_row) ? OP_ERASE :
                         i_latch_only_select ? OP_LATCH : OP_WRITE;
    wire   busy_done = (state == ST_BUSY) & (busy_count == 16'd1);
    wire   ee_run    = (state == ST_BUSY) & (op == OP_EE);

    // ----------------------------------------------------------------
    // unlock and operation sequencer
    // ----------------------------------------------------------------
    always @(posedge i_ref_clk) begin
        if (i_reset) begin
            state            <= ST_IDLE;
            op               <= OP_EE;
            busy_count       <= 16'd0;
            o_cpu_stall      <= 1'b0;
            o_write_start    <= 1'b0;
            o_read_start     <= 1'b0;
            o_mem_read       <= 1'b0;
            o_mem_row_erase  <= 1'b0;
            o_mem_latch_load <= 1'b0;
            o_mem_row_write  <= 1'b0;
            o_mem_ee_write   <= 1'b0;
            o_mem_addr       <= 15'h0000;
            o_mem_wdata      <= `NSW_DATA_RESET;
        end else begin
            o_mem_read       <= 1'b0;
            o_mem_row_erase  <= 1'b0;
            o_mem_latch_load <= 1'b0;
            o_mem_row_write  <= 1'b0;
            o_mem_ee_write   <= 1'b0;
            case (state)
                ST_IDLE, ST_KEY1, ST_KEY2: begin
                    // any other access breaks the chain
                    state <= ST_IDLE;
                    if (i_unlock_key_we &&
                        i_unlock_key_data == `NSW_KEY_FIRST)
                        state <= ST_KEY1;
                    else if (state == ST_KEY1 && i_unlock_key_we &&
                             i_unlock_key_data == `NSW_KEY_SECOND)
                        state <= ST_KEY2;
                    if (allowed) begin
                        op            <= next_op;
                        busy_count    <= op_cycles(next_op);
                        o_write_start <= 1'b1;
                        // eeprom runs in the background
                        o_cpu_stall   <= ~is_eeprom;
                        // eeprom bytes keep their own address
                        o_mem_addr    <= (next_op == OP_ERASE) ?
                            {i_nvm_address_pair[14:`NSW_ROW_LSB],
                             5'h00} : i_nvm_address_pair;
                        state         <= ST_BUSY;
                    end else if (start_req) begin
                        // protected or not unlocked: bit drops
                        o_write_start <= 1'b0;
                    end else if (i_control_we &&
                                 i_read_start_wdata && readable) begin
                        o_read_start <= 1'b1;
                        o_cpu_stall  <= 1'b1;
                        o_mem_addr   <= i_nvm_address_pair;
                        o_mem_read   <= 1'b1;
                        state        <= ST_READ;
                    end
                end
                ST_BUSY: begin
                    if (busy_count == op_cycles(op)) begin
                        // one pulse per operation; only the row is erased
                        o_mem_ee_write   <= (op == OP_EE);
                        o_mem_row_erase  <= (op == OP_ERASE);
                        o_mem_row_write  <= (op == OP_WRITE);
                        o_mem_latch_load <= (op == OP_LATCH);
                        o_mem_wdata      <= o_nvm_data_pair;
                    end
                    busy_count <= busy_count - 16'd1;
                    if (busy_done) begin
                        o_write_start <= 1'b0;
                        o_cpu_stall   <= 1'b0;
                        state         <= ST_IDLE;
                    end
                    // software clearing the bit is ignored here
                end
                ST_READ: begin
                    o_read_start <= 1'b0;
                    o_cpu_stall  <= 1'b0;
                    state        <= ST_IDLE;
                end
                default: state <= ST_IDLE;
            endcase
        end
    end

    // ----------------------------------------------------------------
    // data pair, done flag and interrupt request
    // ----------------------------------------------------------------
    always @(posedge i_ref_clk) begin
        if (i_reset) begin
            o_nvm_data_pair <= `NSW_DATA_RESET;
            o_nvm_done_flag <= 1'b0;
            o_nvm_irq       <= 1'b0;
        end else begin
            if (state == ST_READ)
                o_nvm_data_pair <= i_mem_rdata;
            else if (i_data_we && !ee_run)
                o_nvm_data_pair <= i_data_wdata;
            // completion set wins over a software clear
            if (busy_done && op != OP_LATCH)
                o_nvm_done_flag <= 1'b1;
            else if (i_done_flag_clear)
                o_nvm_done_flag <= 1'b0;
            o_nvm_irq <= i_nvm_done_irq_enable &
                         (o_nvm_done_flag |
                          (busy_done & op != OP_LATCH));
        end
    end

    // write permit and latch contents are held outside and never touched
    // here, so an erase leaves them as they were

endmodule // nsw_sequencer

// [test/nsw_seq_properties.sv]
// port assertions for the nvm self-write sequencer
`timescale 1ns/100ps
module nsw_seq_checker #(
    parameter EE_CYCLES    = 16,
    parameter ERASE_CYCLES = 32
) (
    input logic        i_ref_clk,
    input logic        i_reset,
    input logic        i_unlock_key_we,
    input logic [7:0]  i_unlock_key_data,
    input logic        i_control_we,
    input logic        i_write_start_wdata,
    input logic        i_region_select,
    input logic        i_write_permit,
    input logic        i_write_protect,
    input logic        i_nvm_done_irq_enable,
    input logic        o_mem_read,
    input logic        o_mem_row_erase,
    input logic        o_mem_ee_write,
    input logic [14:0] o_mem_addr,
    input logic        o_cpu_stall,
    input logic        o_write_start,
    input logic        o_read_start,
    input logic        o_nvm_done_flag,
    input logic        o_nvm_irq
);
    localparam int EE_D = EE_CYCLES - 1;
    localparam int ER_D = ERASE_CYCLES - 1;
    default clocking @(posedge i_ref_clk); endclocking
    default disable iff (i_reset);
    property p_unlock; $rose(o_write_start) |-> $past(i_control_we
        && i_write_start_wdata && i_write_permit && !i_write_protect)
        && $past(i_unlock_key_we && i_unlock_key_data == 8'haa, 2)
        && $past(i_unlock_key_we && i_unlock_key_data == 8'h55, 3);
    endproperty
    a_unlock: assert property (p_unlock)
        else $error("start without unlock");
    property p_stall;
        $rose(o_write_start) && !$past(i_region_select) |-> o_cpu_stall;
    endproperty
    a_stall: assert property (p_stall) else $error("no stall");
    // the repeat count holds for any eeprom count of 4 or more
    property p_ee_run;
        o_mem_ee_write |-> (o_write_start && !o_cpu_stall) [*3];
    endproperty
    a_ee_run: assert property (p_ee_run) else $error("ee run");
    property p_ee_done;
        o_mem_ee_write |-> ##EE_D !o_write_start && o_nvm_done_flag;
    endproperty
    a_ee_done: assert property (p_ee_done) else $error("ee end");
    property p_erase; o_mem_row_erase |-> o_mem_addr[4:0] == 5'h00
        && o_cpu_stall ##ER_D !o_cpu_stall && o_nvm_done_flag;
    endproperty
    a_erase: assert property (p_erase) else $error("erase");
    property p_irq;
        $rose(o_nvm_done_flag) && i_nvm_done_irq_enable |=> o_nvm_irq;
    endproperty
    a_irq: assert property (p_irq) else $error("irq late");
    property p_read; o_mem_read |-> o_read_start && o_cpu_stall
        ##1 !o_read_start && !o_cpu_stall;
    endproperty
    a_read: assert property (p_read) else $error("read");
    property p_ee_map; o_mem_ee_write |-> o_mem_addr >= 15'h7000
        && o_mem_addr <= 15'h70ff;
    endproperty
    a_ee_map: assert property (p_ee_map) else $error("ee addr");
endmodule // nsw_seq_checker

bind nsw_sequencer nsw_seq_checker #(.EE_CYCLES(EE_CYCLES),
    .ERASE_CYCLES(ERASE_CYCLES)) i_nsw_seq_checker (
    .i_ref_clk(i_ref_clk),
    .i_reset(i_reset),
    .i_unlock_key_we(i_unlock_key_we),
    .i_unlock_key_data(i_unlock_key_data),
    .i_control_we(i_control_we),
    .i_write_start_wdata(i_write_start_wdata),
    .i_region_select(i_region_select),
    .i_write_permit(i_write_permit),
    .i_write_protect(i_write_protect),
    .i_nvm_done_irq_enable(i_nvm_done_irq_enable),
    .o_mem_read(o_mem_read),
    .o_mem_row_erase(o_mem_row_erase),
    .o_mem_ee_write(o_mem_ee_write),
    .o_mem_addr(o_mem_addr),
    .o_cpu_stall(o_cpu_stall),
    .o_write_start(o_write_start),
    .o_read_start(o_read_start),
    .o_nvm_done_flag(o_nvm_done_flag),
    .o_nvm_irq(o_nvm_irq));

// [test/nsw_core_model.sv]
// core model: issues unlock and control register writes
`timescale 1ns/100ps
module nsw_core_model (
    input  wire       i_ref_clk,
    output reg        o_key_we,
    output reg  [7:0] o_key_data,
    output reg        o_ctl_we,
    output reg        o_ws,
    output reg        o_rs
);
    initial {o_key_we, o_key_data, o_ctl_we, o_ws, o_rs} = 12'h000;
    task ctl(input ws, input rs);
        @(negedge i_ref_clk);
        o_key_we = 1'h0;
        o_ctl_we = 1'h1;
        o_ws = ws;
        o_rs = rs;
        @(negedge i_ref_clk);
        {o_ctl_we, o_ws, o_rs} = 3'h0;
    endtask
    // interrupts taken as masked, so nothing slips between the steps
    task unlock(input [7:0] k1, input [7:0] k2, input gap);
        @(negedge i_ref_clk);
        o_key_we = 1'h1;
        o_key_data = k1;
        @(negedge i_ref_clk);
        o_key_data = k2;
        if (gap) begin
            @(negedge i_ref_clk);
            o_key_we = 1'h0;
        end
        ctl(1'h1, 1'h0);
        o_key_data = ~k2;
    endtask
endmodule // nsw_core_model

// [test/tb_nsw_sequencer.sv]
// self-checking bench for the nvm self-write sequencer
`timescale 1ns/100ps
`define CHK(g, e) begin \
    n_tests++; \
    if ((g) !== (e)) begin \
        bad_count++; \
        $display("mismatch %0t got %h exp %h", $time, g, e); \
    end \
end
module tb_nsw_sequencer;
    logic        i_ref_clk, i_reset, i_unlock_key_we, i_control_we;
    logic        i_write_start_wdata, i_read_start_wdata, i_region_select;
    logic        i_write_permit, i_erase_select, i_latch_only_select;
    logic        i_data_we, i_write_protect, i_done_flag_clear;
    logic        i_nvm_done_irq_enable, o_mem_read, o_mem_row_erase;
    logic        o_mem_latch_load, o_mem_row_write, o_mem_ee_write;
    logic        o_cpu_stall, o_write_start, o_read_start, o_nvm_irq;
    logic        o_nvm_done_flag;
    logic [7:0]  i_unlock_key_data;
    logic [13:0] i_data_wdata, i_mem_rdata, o_mem_wdata, o_nvm_data_pair;
    logic [13:0] ll_data;
    logic [14:0] i_nvm_address_pair, o_mem_addr, er_addr;
    int          bad_count = 0, n_tests = 0;
    int          n_ee = 0, n_er = 0, n_ll = 0, n_rw = 0;
    nsw_sequencer #(.EE_CYCLES(4), .ERASE_CYCLES(4), .FLASH_CYCLES(4))
    i_nsw_sequencer (.i_ref_clk, .i_reset, .i_unlock_key_we,
        .i_unlock_key_data, .i_control_we, .i_write_start_wdata,
        .i_read_start_wdata, .i_region_select, .i_write_permit,
        .i_erase_select, .i_latch_only_select, .i_nvm_address_pair,
        .i_data_we, .i_data_wdata, .i_write_protect, .i_done_flag_clear,
        .i_nvm_done_irq_enable, .i_mem_rdata, .o_mem_read, .o_mem_row_erase,
        .o_mem_latch_load, .o_mem_row_write, .o_mem_ee_write, .o_mem_addr,
        .o_mem_wdata, .o_cpu_stall, .o_write_start, .o_read_start,
        .o_nvm_data_pair, .o_nvm_done_flag, .o_nvm_irq);
    nsw_core_model i_nsw_core_model (.i_ref_clk, .o_key_we(i_unlock_key_we),
        .o_key_data(i_unlock_key_data), .o_ctl_we(i_control_we),
        .o_ws(i_write_start_wdata), .o_rs(i_read_start_wdata));
    // array answers a fixed function of the address, so reads are checkable
    assign i_mem_rdata = ~o_mem_addr[13:0];
    always @(posedge i_ref_clk) begin
        n_ee <= n_ee + o_mem_ee_write;
        n_er <= n_er + o_mem_row_erase;
        n_ll <= n_ll + o_mem_latch_load;
        n_rw <= n_rw + o_mem_row_write;
        if (o_mem_row_erase) er_addr <= o_mem_addr;
        if (o_mem_latch_load) ll_data <= o_mem_wdata;
    end
    initial begin
        i_ref_clk = 1'h0;
        forever #12.5 i_ref_clk = ~i_ref_clk;
    end
    task results;
        $display("checks %0d mismatches %0d", n_tests, bad_count);
        if (bad_count == 0 && n_tests > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask
    task idle;
        int k;
        for (k = 0; k < 40 && (o_write_start | o_cpu_stall | o_read_start)
            !== 1'h0; k++) @(negedge i_ref_clk);
        if (k == 40) begin
            bad_count++;
            results;
        end
    endtask
    task clr;
        @(negedge i_ref_clk);
        i_done_flag_clear = 1'h1;
        @(negedge i_ref_clk);
        i_done_flag_clear = 1'h0;
        `CHK(o_nvm_done_flag, 1'h0)
    endtask
    task op(input [4:0] lv, input [14:0] a, input [7:0] k1, input gap);
        @(negedge i_ref_clk);
        {i_region_select, i_write_permit, i_erase_select,
            i_latch_only_select, i_write_protect} = lv;
        i_nvm_address_pair = a;
        i_data_we = 1'h0;
        i_nsw_core_model.unlock(k1, 8'haa, gap);
    endtask
    task t_ee;
        op(5'h18, 15'h7005, 8'h55, 1'h0);
        `CHK({o_write_start, o_cpu_stall}, 2'h2)
        i_nsw_core_model.ctl(1'h0, 1'h0);
        `CHK(o_write_start, 1'h1)
        idle;
        `CHK(o_mem_addr, 15'h7005)
        @(negedge i_ref_clk);
        `CHK({n_ee, n_er}, {32'h1, 32'h0})
        `CHK({o_nvm_done_flag, o_nvm_irq}, 2'h3)
        clr;
    endtask
    task t_refuse;
        int s;
        s = n_ee + n_er + n_ll + n_rw;
        for (int c = 0; c < 6; c++) begin
            op({c == 3 || c == 5, c != 2, 2'h2, c == 4}, c == 3 ? 15'h0004
                : (c == 5 ? 15'h0006 : 15'h0045), c ? 8'h55 : 8'haa, c == 1);
            `CHK({o_write_start, o_cpu_stall}, 2'h0)
        end
        @(negedge i_ref_clk);
        `CHK(n_ee + n_er + n_ll + n_rw, s)
    endtask
    task t_flash;
        for (int r = 0; r < 2; r++) begin
            op({r[0], 4'hc}, r ? 15'h0002 : 15'h1234, 8'h55, 1'h0);
            `CHK(o_cpu_stall, 1'h1)
            idle;
            `CHK(er_addr, r ? 15'h0000 : 15'h1220)
            `CHK(o_nvm_done_flag, 1'h1)
            clr;
        end
        i_data_we = 1'h1;
        i_data_wdata = 14'h1abc;
        op(5'h0a, 15'h0101, 8'h55, 1'h0);
        idle;
        @(negedge i_ref_clk);
        `CHK({n_ll, ll_data, o_nvm_done_flag}, {32'h1, 14'h1abc, 1'h0})
        op(5'h08, 15'h0101, 8'h55, 1'h0);
        idle;
        `CHK({n_rw, n_er, o_nvm_done_flag}, {32'h1, 32'h2, 1'h1})
    endtask
    task t_read;
        logic [14:0] a;
        for (int j = 0; j < 3; j++) begin
            a = j == 0 ? 15'h0006 : (j == 1 ? 15'h70ff : 15'h7fff);
            @(negedge i_ref_clk);
            i_region_select = j < 2;
            i_nvm_address_pair = a;
            i_nsw_core_model.ctl(1'h0, 1'h1);
            idle;
            `CHK(o_nvm_data_pair, ~a[13:0])
        end
    endtask
    initial begin
        {i_region_select, i_write_permit, i_erase_select, i_data_wdata,
            i_latch_only_select, i_write_protect, i_data_we,
            i_done_flag_clear, i_nvm_address_pair} = 36'h0;
        i_nvm_done_irq_enable = 1'h1;
        i_reset = 1'h1;
        repeat (2) @(negedge i_ref_clk);
        i_reset = 1'h0;
        t_ee;
        t_refuse;
        t_flash;
        t_read;
        results;
    end
endmodule // tb_nsw_sequencer
